// ---- hdl/t16wm_consts.vh ----
// Purpose: constants for the 16-bit timer waveform mode control block
// Assumes: 8-bit register port, word-per-register map
// Notes:   offsets are local register indices on the plain port
`ifndef T16WM_CONSTS_VH
`define T16WM_CONSTS_VH
`define T16WM_ADDR_CTRL_A   4'h0
`define T16WM_ADDR_CTRL_B   4'h1
`define T16WM_ADDR_CNT_L    4'h2
`define T16WM_ADDR_CNT_H    4'h3
`define T16WM_ADDR_CMPA_L   4'h4
`define T16WM_ADDR_CMPA_H   4'h5
`define T16WM_ADDR_CMPB_L   4'h6
`define T16WM_ADDR_CMPB_H   4'h7
`define T16WM_ADDR_CAP_L    4'h8
`define T16WM_ADDR_CAP_H    4'h9
`define T16WM_ADDR_FLAGS    4'ha
`define T16WM_ADDR_DIR      4'hb
`define T16WM_CTRL_A_RST    8'h00
`define T16WM_CTRL_B_RST    8'h00
`define T16WM_MODE_A_HI     7
`define T16WM_MODE_A_LO     6
`define T16WM_MODE_B_HI     5
`define T16WM_MODE_B_LO     4
`define T16WM_FORCE_A       3
`define T16WM_FORCE_B       2
`define T16WM_FLAG_OVF      0
`define T16WM_FLAG_MA       1
`define T16WM_FLAG_MB       2
`define T16WM_TOP_MAX       16'hffff
`define T16WM_TOP_8         16'h00ff
`define T16WM_TOP_9         16'h01ff
`define T16WM_TOP_10        16'h03ff
`define T16WM_DIV_8         3'h7
`define T16WM_DIV_64        6'h3f
`define T16WM_DIV_256       8'hff
`define T16WM_DIV_1024      10'h3ff
`endif

// ---- hdl/t16wm_top.v ----
// Purpose: waveform mode decode, counter and compare outputs of a 16-bit
//          timer, reached over a plain register port
// Assumes: external count pin is asynchronous; CPU clears flags by
//          writing one
// Notes:   16-bit registers take the held high byte on write of the low byte
`include "t16wm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module t16wm_top
(
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // External count pin
  input  wire       external_count_pin,
  // Compare output pins
  output reg        wave_out_a,
  output reg        wave_out_a_oe,
  output reg        wave_out_b,
  output reg        wave_out_b_oe
);

  localparam DIR_UP   = 1'b0;
  localparam DIR_DOWN = 1'b1;

  reg  [7:0]  ctrl_a_reg;
  reg  [7:0]  ctrl_b_reg;
  reg  [15:0] cnt_reg;
  reg  [15:0] cmpa_reg;
  reg  [15:0] cmpb_reg;
  reg  [15:0] cmpa_buf_reg;
  reg  [15:0] cmpb_buf_reg;
  reg  [15:0] cap_reg;
  reg  [7:0]  temp_reg;
  reg  [2:0]  flags_reg;
  reg  [1:0]  dir_bits_reg;
  reg         dir_reg;
  reg         wave_a_reg;
  reg         wave_b_reg;
  reg  [9:0]  pre_reg;
  reg         ext_s1_reg;
  reg         ext_s2_reg;
  reg         ext_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire [3:0] wave_mode = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
  wire [2:0] clock_select = ctrl_b_reg[2:0];
  wire [1:0] out_mode_a = ctrl_a_reg[7:6];
  wire [1:0] out_mode_b = ctrl_a_reg[5:4];
  wire       wave_mode_top_bit = wave_mode[3];

  // Single-slope PWM: modes 5,6,7,14,15
  function is_fast;
    input [3:0] m;
    begin
      is_fast = (m == 4'd5) || (m == 4'd6) || (m == 4'd7) ||
                (m == 4'd14) || (m == 4'd15);
    end
  endfunction

  // Dual-slope PWM: modes 1,2,3,8,9,10,11
  function is_dual;
    input [3:0] m;
    begin
      is_dual = (m == 4'd1) || (m == 4'd2) || (m == 4'd3) ||
                ((m >= 4'd8) && (m <= 4'd11));
    end
  endfunction

  wire fast_mode = is_fast(wave_mode);
  wire dual_mode = is_dual(wave_mode);
  wire pwm_mode  = fast_mode | dual_mode;
  wire freq_corr = (wave_mode == 4'd8) || (wave_mode == 4'd9);
  wire ctc_mode  = (wave_mode == 4'd4) || (wave_mode == 4'd12);

  // TOP source per mode
  reg [15:0] top_val;
  always @*
  begin
    case (wave_mode)
      4'd1, 4'd5:                top_val = `T16WM_TOP_8;
      4'd2, 4'd6:                top_val = `T16WM_TOP_9;
      4'd3, 4'd7:                top_val = `T16WM_TOP_10;
      4'd4, 4'd9, 4'd11, 4'd15:  top_val = cmpa_reg;
      4'd8, 4'd10, 4'd12, 4'd14: top_val = cap_reg;
      default:                   top_val = `T16WM_TOP_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and tick enable; external pin synchronised first
  wire ext_rise = ext_s2_reg & ~ext_s3_reg;
  wire ext_fall = ~ext_s2_reg & ext_s3_reg;
  reg  tick;
  always @*
  begin
    case (clock_select)
      3'd1:    tick = 1'b1;
      3'd2:    tick = (pre_reg[2:0] == `T16WM_DIV_8);
      3'd3:    tick = (pre_reg[5:0] == `T16WM_DIV_64);
      3'd4:    tick = (pre_reg[7:0] == `T16WM_DIV_256);
      3'd5:    tick = (pre_reg == `T16WM_DIV_1024);
      3'd6:    tick = ext_fall;
      3'd7:    tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end
  wire timer_tick_enable = tick;

  ////////////////////////////////////////////////////////////////////////
  // Counter events
  wire at_top    = (cnt_reg == top_val);
  wire at_bottom = (cnt_reg == 16'h0000);
  wire match_a   = (cnt_reg == cmpa_reg);
  wire match_b   = (cnt_reg == cmpb_reg);
  wire cnt_wr    = reg_wr && ((reg_addr == `T16WM_ADDR_CNT_H) ||
                              (reg_addr == `T16WM_ADDR_CNT_L));
  // Load point of double buffers
  wire buf_load  = timer_tick_enable &&
                   (freq_corr ? at_bottom : at_top);

  // Overflow timing per mode
  reg ovf_evt;
  always @*
  begin
    if (fast_mode)
      ovf_evt = timer_tick_enable && at_top;
    else if (dual_mode)
      ovf_evt = timer_tick_enable && at_bottom &&
                (dir_reg == DIR_DOWN);
    else
      ovf_evt = timer_tick_enable && (cnt_reg == `T16WM_TOP_MAX);
  end

  // Counter and direction
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 16'h0000;
      dir_reg <= DIR_UP;
    end
    else if (cnt_wr)
    begin
      if (reg_addr == `T16WM_ADDR_CNT_L)
        cnt_reg <= {temp_reg, reg_wdata};
    end
    else if (timer_tick_enable)
    begin
      if (dual_mode)
      begin
        if (at_top)
        begin
          dir_reg <= DIR_DOWN;
          cnt_reg <= cnt_reg - 16'h0001;
        end
        else if (at_bottom && dir_reg == DIR_DOWN)
        begin
          dir_reg <= DIR_UP;
          cnt_reg <= 16'h0001;
        end
        else if (dir_reg == DIR_UP)
          cnt_reg <= cnt_reg + 16'h0001;
        else
          cnt_reg <= cnt_reg - 16'h0001;
      end
      else
      begin
        dir_reg <= DIR_UP;
        // Only a real match resets in CLEAR_ON_MATCH_MODE; force never does
        if ((ctc_mode || fast_mode) && at_top)
          cnt_reg <= 16'h0000;
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform units; force only outside PWM
  // Strobe judged against the mode written beside it
  wire       ctl_a_wr = reg_wr && (reg_addr == `T16WM_ADDR_CTRL_A);
  wire [3:0] wr_mode  = {ctrl_b_reg[4:3], reg_wdata[1:0]};
  wire       wr_pwm   = is_fast(wr_mode) | is_dual(wr_mode);
  wire force_a = ctl_a_wr && reg_wdata[`T16WM_FORCE_A] && !wr_pwm;
  wire force_b = ctl_a_wr && reg_wdata[`T16WM_FORCE_B] && !wr_pwm;

  // Next output level for one channel
  function wave_next;
    input       cur;
    input [1:0] om;
    input       m_evt;
    input       t_evt;
    input       fast;
    input       dual;
    input       down;
    input       tog_ok;
    input       top_eq;
    begin
      wave_next = cur;
      if (!fast && !dual)
      begin
        if (m_evt)
          case (om)
            2'b01:   wave_next = ~cur;
            2'b10:   wave_next = 1'b0;
            2'b11:   wave_next = 1'b1;
            default: wave_next = cur;
          endcase
      end
      else if (om == 2'b01)
      begin
        if (m_evt && tog_ok)
          wave_next = ~cur;
      end
      else if (fast && om[1])
      begin
        if (t_evt)
          wave_next = ~om[0];
        else if (m_evt && !top_eq)
          wave_next = om[0];
      end
      else if (dual && om[1] && m_evt)
        wave_next = down ? ~om[0] : om[0];
    end
  endfunction

  wire tick_ma = timer_tick_enable && match_a && !cnt_wr;
  wire tick_mb = timer_tick_enable && match_b && !cnt_wr;
  wire tick_t  = timer_tick_enable && at_top;
  // The top turns downward and the bottom upward, so that a compare
  // value at either extreme holds the pin steady
  wire going_down = ((dir_reg == DIR_DOWN) && !at_bottom) || at_top;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end
    else
    begin
      // A force acts with the output mode written beside it
      if (force_a)
        wave_a_reg <= wave_next(wave_a_reg, reg_wdata[7:6], 1'b1, 1'b0,
                                1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      else
        wave_a_reg <= wave_next(wave_a_reg, out_mode_a, tick_ma,
                                tick_t, fast_mode, dual_mode, going_down,
                                wave_mode_top_bit, cmpa_reg == top_val);
      // Channel B mode 01 in PWM is reserved: kept disconnected
      if (force_b)
        wave_b_reg <= wave_next(wave_b_reg, reg_wdata[5:4], 1'b1, 1'b0,
                                1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      else
        wave_b_reg <= wave_next(wave_b_reg, out_mode_b, tick_mb,
                                tick_t, fast_mode, dual_mode, going_down,
                                1'b0, cmpb_reg == top_val);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin override and driver enable
  wire conn_a = (out_mode_a != 2'b00) &&
                !(pwm_mode && out_mode_a == 2'b01 && !wave_mode_top_bit);
  wire conn_b = (out_mode_b != 2'b00) &&
                !(pwm_mode && out_mode_b == 2'b01);
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wave_out_a    <= 1'b0;
      wave_out_a_oe <= 1'b0;
      wave_out_b    <= 1'b0;
      wave_out_b_oe <= 1'b0;
    end
    else
    begin
      wave_out_a    <= wave_a_reg;
      wave_out_b    <= wave_b_reg;
      wave_out_a_oe <= conn_a && dir_bits_reg[0];
      wave_out_b_oe <= conn_b && dir_bits_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, buffers and flags
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_a_reg   <= `T16WM_CTRL_A_RST;
      ctrl_b_reg   <= `T16WM_CTRL_B_RST;
      cmpa_reg     <= 16'h0000;
      cmpb_reg     <= 16'h0000;
      cmpa_buf_reg <= 16'h0000;
      cmpb_buf_reg <= 16'h0000;
      cap_reg      <= 16'h0000;
      temp_reg     <= 8'h00;
      flags_reg    <= 3'b000;
      dir_bits_reg <= 2'b00;
    end
    else
    begin
      // Immediate modes write straight through
      if (!pwm_mode)
      begin
        cmpa_reg <= cmpa_buf_reg;
        cmpb_reg <= cmpb_buf_reg;
      end
      else if (buf_load)
      begin
        cmpa_reg <= cmpa_buf_reg;
        cmpb_reg <= cmpb_buf_reg;
      end
      if (reg_wr)
      begin
        if (reg_addr == `T16WM_ADDR_CTRL_A)
          ctrl_a_reg <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
        else if (reg_addr == `T16WM_ADDR_CTRL_B)
          ctrl_b_reg <= {3'b000, reg_wdata[4:0]};
        else if (reg_addr == `T16WM_ADDR_CNT_H ||
                 reg_addr == `T16WM_ADDR_CMPA_H ||
                 reg_addr == `T16WM_ADDR_CMPB_H ||
                 reg_addr == `T16WM_ADDR_CAP_H)
          temp_reg <= reg_wdata;
        else if (reg_addr == `T16WM_ADDR_CMPA_L)
          cmpa_buf_reg <= {temp_reg, reg_wdata};
        else if (reg_addr == `T16WM_ADDR_CMPB_L)
          cmpb_buf_reg <= {temp_reg, reg_wdata};
        else if (reg_addr == `T16WM_ADDR_CAP_L)
          cap_reg <= {temp_reg, reg_wdata};
        else if (reg_addr == `T16WM_ADDR_DIR)
          dir_bits_reg <= reg_wdata[1:0];
      end
      // Set wins over a write-one clear; force never sets a flag
      flags_reg[`T16WM_FLAG_OVF] <= ovf_evt |
        (flags_reg[`T16WM_FLAG_OVF] & ~(reg_wr &&
         reg_addr == `T16WM_ADDR_FLAGS && reg_wdata[0]));
      flags_reg[`T16WM_FLAG_MA] <= tick_ma |
        (flags_reg[`T16WM_FLAG_MA] & ~(reg_wr &&
         reg_addr == `T16WM_ADDR_FLAGS && reg_wdata[1]));
      flags_reg[`T16WM_FLAG_MB] <= tick_mb |
        (flags_reg[`T16WM_FLAG_MB] & ~(reg_wr &&
         reg_addr == `T16WM_ADDR_FLAGS && reg_wdata[2]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and pin synchroniser
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_reg    <= 10'h000;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end
    else
    begin
      pre_reg    <= pre_reg + 10'h001;
      ext_s1_reg <= external_count_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `T16WM_ADDR_CTRL_A)
        reg_rdata <= ctrl_a_reg;
      else if (reg_addr == `T16WM_ADDR_CTRL_B)
        reg_rdata <= ctrl_b_reg;
      else if (reg_addr == `T16WM_ADDR_CNT_L)
        reg_rdata <= cnt_reg[7:0];
      else if (reg_addr == `T16WM_ADDR_CNT_H)
        reg_rdata <= cnt_reg[15:8];
      else if (reg_addr == `T16WM_ADDR_CMPA_L)
        reg_rdata <= cmpa_buf_reg[7:0];
      else if (reg_addr == `T16WM_ADDR_CMPA_H)
        reg_rdata <= cmpa_buf_reg[15:8];
      else if (reg_addr == `T16WM_ADDR_CMPB_L)
        reg_rdata <= cmpb_buf_reg[7:0];
      else if (reg_addr == `T16WM_ADDR_CMPB_H)
        reg_rdata <= cmpb_buf_reg[15:8];
      else if (reg_addr == `T16WM_ADDR_CAP_L)
        reg_rdata <= cap_reg[7:0];
      else if (reg_addr == `T16WM_ADDR_CAP_H)
        reg_rdata <= cap_reg[15:8];
      else if (reg_addr == `T16WM_ADDR_FLAGS)
        reg_rdata <= {5'b00000, flags_reg};
      else if (reg_addr == `T16WM_ADDR_DIR)
        reg_rdata <= {6'b000000, dir_bits_reg};
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// ---- verification/t16wm_pin_model.sv ----
// Purpose: board side of the two compare output pins
// Assumes: each pin carries a weak pull-up on the board
// Notes:   a released pin reads high, never the last driven level
`timescale 1ns/1ps
`default_nettype none
module t16wm_pin_model
(
  // Design side
  input  wire logic wave_out_a,
  input  wire logic wave_out_a_oe,
  input  wire logic wave_out_b,
  input  wire logic wave_out_b_oe,
  // Board side
  output wire logic pin_a,
  output wire logic pin_b
);
  // Pull-up wins whenever the driver is off
  assign pin_a = wave_out_a_oe ? wave_out_a : 1'b1;
  assign pin_b = wave_out_b_oe ? wave_out_b : 1'b1;
endmodule
`default_nettype wire

// ---- verification/t16wm_top_monitor.sv ----
// Purpose: port-level checks of the timer waveform block
// Assumes: control and direction bits are shadowed from port writes
// Notes:   pin enables are judged once their cause held two cycles
`timescale 1ns/1ps
`default_nettype none
module t16wm_monitor
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Compare pins
  input wire logic       wave_out_a,
  input wire logic       wave_out_a_oe,
  input wire logic       wave_out_b,
  input wire logic       wave_out_b_oe
);
  logic [7:0] ca_reg;
  logic [4:0] cb_reg;
  logic [1:0] dir_reg;
  logic [3:0] mode;
  logic       conn_a;
  logic       conn_b;
  logic       stop;
  logic       frc;
  logic [7:0] ca_rb;
  // Pulse width modulation modes: every mode but 0, 4, 12 and 13
  function automatic logic t16wm_pwm(input logic [3:0] m);
    return !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
  endfunction
  // Shadow registers follow the writes of the port
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ca_reg  <= 8'h00;
      cb_reg  <= 5'h00;
      dir_reg <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h0)
        ca_reg <= reg_wdata & 8'hf3;
      if (reg_addr == 4'h1)
        cb_reg <= reg_wdata[4:0];
      if (reg_addr == 4'hb)
        dir_reg <= reg_wdata[1:0];
    end
  // Connection of each pin as the rules decide it
  assign mode   = {cb_reg[4:3], ca_reg[1:0]};
  assign conn_a = dir_reg[0] && (ca_reg[7] ||
                  (ca_reg[6] && (!t16wm_pwm(mode) || mode[3])));
  assign conn_b = dir_reg[1] && (ca_reg[5] ||
                  (ca_reg[4] && !t16wm_pwm(mode)));
  assign stop   = cb_reg[2:0] == 3'h0;
  assign frc    = reg_wr && reg_addr == 4'h0 && reg_wdata[3] && stop;
  assign ca_rb  = ca_reg;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_ctla_readback: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata == $past(ca_rb))
    else $error("control a readback wrong");
  a_ctlb_readback: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h1 |->
    reg_rdata == {3'h0, $past(cb_reg)})
    else $error("control b readback wrong");
  a_oe_a_conn: assert property (
    conn_a == $past(conn_a) && conn_a == $past(conn_a, 2) |->
    wave_out_a_oe == conn_a)
    else $error("pin a enable wrong");
  a_oe_b_conn: assert property (
    conn_b == $past(conn_b) && conn_b == $past(conn_b, 2) |->
    wave_out_b_oe == conn_b)
    else $error("pin b enable wrong");
  a_force_clear: assert property (
    frc && reg_wdata[7:6] == 2'b10 &&
    !t16wm_pwm({cb_reg[4:3], reg_wdata[1:0]}) |-> ##[1:3] !wave_out_a)
    else $error("forced clear missing");
  a_force_set: assert property (
    frc && reg_wdata[7:6] == 2'b11 &&
    !t16wm_pwm({cb_reg[4:3], reg_wdata[1:0]}) |-> ##[1:3] wave_out_a)
    else $error("forced set missing");
  a_force_void: assert property (
    frc && t16wm_pwm({cb_reg[4:3], reg_wdata[1:0]}) |->
    ##1 $stable(wave_out_a) [*3])
    else $error("force acted in pwm mode");
endmodule
bind t16wm_top t16wm_monitor i_t16wm_monitor
(
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wave_out_a(wave_out_a),
  .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
  .wave_out_b_oe(wave_out_b_oe)
);
`default_nettype wire

// ---- verification/t16wm_top_tb.sv ----
// Purpose: register-driven tests of the timer waveform block
// Assumes: counter stopped while forced matches are tried
// Notes:   duty is counted on the pin over one or two full periods
`include "t16wm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module t16wm_top_tb;
  logic       core_clk  = 1'b0;
  logic       rst       = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       ext_pin   = 1'b0;
  logic [7:0] d;
  int         mismatches = 0;
  int         checked    = 0;
  wire  [7:0] reg_rdata;
  wire        wa, wa_oe, wb, wb_oe, pin_a, pin_b;
  // Design and the board pins
  t16wm_top i_t16wm_top (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_count_pin(ext_pin), .wave_out_a(wa),
    .wave_out_a_oe(wa_oe), .wave_out_b(wb), .wave_out_b_oe(wb_oe));
  t16wm_pin_model i_t16wm_pin_model (.wave_out_a(wa),
    .wave_out_a_oe(wa_oe), .wave_out_b(wb), .wave_out_b_oe(wb_oe),
    .pin_a(pin_a), .pin_b(pin_b));
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e,
                       input string nm);
    rd(a);
    `CHK(nm, e, d)
  endtask
  // Pulses on the count pin, then time for the synchroniser
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      ext_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
  // High byte first, it waits in the shared holding byte
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic cfg(input logic [7:0] ca, input logic pin,
                     input logic oe);
    wr(`T16WM_ADDR_CTRL_A, ca);
    repeat (4) @(negedge core_clk);
    `CHK("pin_a", pin, pin_a)
    `CHK("oe_a", oe, wa_oe)
  endtask
  // Restart from zero, settle two windows, count high cycles in one
  task automatic run(input logic [7:0] ca, input logic [7:0] cb,
    input logic [15:0] cmp, input logic [15:0] cap, input int win,
    input logic [15:0] hi, input logic ovf);
    logic [15:0] n;
    wr(`T16WM_ADDR_CTRL_B, 8'h00);
    wr16(`T16WM_ADDR_CNT_L, 16'h0000);
    wr16(`T16WM_ADDR_CAP_L, cap);
    wr16(`T16WM_ADDR_CMPA_L, cmp);
    wr(`T16WM_ADDR_CTRL_A, ca);
    wr(`T16WM_ADDR_CTRL_B, cb);
    repeat (2 * win) @(negedge core_clk);
    wr(`T16WM_ADDR_FLAGS, 8'h07);
    n = 16'h0000;
    repeat (win) @(negedge core_clk) n = n + {15'h0, pin_a};
    `CHK("high_count", hi, n)
    rd(`T16WM_ADDR_FLAGS);
    `CHK("match_flag", 1'b1, d[1])
    `CHK("overflow", ovf, d[0])
  endtask
  task automatic close_out();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog, about three and a half times the expected run
  initial
  begin
    #600000;
    mismatches++;
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(`T16WM_ADDR_CTRL_A, 8'h00, "ctrl_a");
    rdchk(`T16WM_ADDR_CTRL_B, 8'h00, "ctrl_b");
    wr(4'hc, 8'hff);
    rdchk(4'hc, 8'h00, "unmapped");
    wr(`T16WM_ADDR_DIR, 8'h03);
    cfg(8'h48, 1'b1, 1'b1);
    rdchk(`T16WM_ADDR_CTRL_A, 8'h40, "ctrl_a");
    cfg(8'h88, 1'b0, 1'b1);
    cfg(8'hc8, 1'b1, 1'b1);
    cfg(8'h48, 1'b0, 1'b1);
    rdchk(`T16WM_ADDR_FLAGS, 8'h00, "flags");
    cfg(8'h01, 1'b1, 1'b0);
    cfg(8'hc9, 1'b0, 1'b1);
    cfg(8'h10, 1'b1, 1'b0);
    `CHK("oe_b", 1'b1, wb_oe)
    `CHK("pin_b", 1'b0, pin_b)
    wr(`T16WM_ADDR_CTRL_A, 8'h34);
    repeat (4) @(negedge core_clk);
    `CHK("pin_b", 1'b1, pin_b)
    wr(`T16WM_ADDR_DIR, 8'h01);
    repeat (4) @(negedge core_clk);
    `CHK("oe_b", 1'b0, wb_oe)
    wr(`T16WM_ADDR_DIR, 8'h03);
    wr(`T16WM_ADDR_CTRL_B, 8'h08);
    cfg(8'h41, 1'b1, 1'b0);
    // Pwm writes keep the force bits at zero
    run(8'h81, 8'h09, 16'h0010, 16'h0000, 256, 16'd17, 1'b1);
    run(8'hc1, 8'h09, 16'h0010, 16'h0000, 256, 16'd239, 1'b1);
    run(8'h81, 8'h09, 16'h00ff, 16'h0000, 256, 16'd256, 1'b1);
    run(8'h81, 8'h01, 16'h0040, 16'h0000, 510, 16'd128, 1'b1);
    run(8'hc1, 8'h01, 16'h0040, 16'h0000, 510, 16'd382, 1'b1);
    run(8'h81, 8'h01, 16'h0000, 16'h0000, 510, 16'd0, 1'b1);
    run(8'h80, 8'h11, 16'h0010, 16'h0040, 128, 16'd32, 1'b1);
    run(8'h40, 8'h09, 16'h000f, 16'h0000, 64, 16'd32, 1'b0);
    run(8'h42, 8'h19, 16'h0005, 16'h001f, 64, 16'd32, 1'b1);
    run(8'h40, 8'h0a, 16'h0001, 16'h0000, 64, 16'd32, 1'b0);
    // Count pin: rising edges, then falling edges
    wr(`T16WM_ADDR_CTRL_B, 8'h00);
    wr16(`T16WM_ADDR_CNT_L, 16'h0000);
    wr(`T16WM_ADDR_CTRL_B, 8'h07);
    ext_pulses(5);
    rdchk(`T16WM_ADDR_CNT_L, 8'h05, "ext_rise");
    wr(`T16WM_ADDR_CTRL_B, 8'h06);
    ext_pulses(3);
    rdchk(`T16WM_ADDR_CNT_L, 8'h08, "ext_fall");
    close_out();
  end
endmodule
`default_nettype wire
